// ===== core/bmc_pkg.sv
package bmc_pkg;
	// clock and bit timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 3330;
	localparam int HALF_BIT_CYC = BIT_TIME_NS / (2 * CLK_PERIOD_NS);
	// cycles the receiver stays deaf after own drive ends
	localparam int RX_GUARD_CYC = 4;
	// transmit buffer shape
	localparam int TX_BUF_DEPTH = 2;
	localparam int TX_BUF_WIDTH = 1;
	// orientation select encoding
	localparam logic PIN_SEL_A = 1'b0;
	localparam logic PIN_SEL_B = 1'b1;
	// idle (released) level seen on the wire
	localparam logic LINE_IDLE_LVL = 1'b1;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_LEAD = 4'h2,
		TX_BITS = 4'h4,
		TX_TAIL = 4'h8
	} tx_state_t;
endpackage

// ===== core/cc_link_if.sv
`timescale 1ns/1ns
interface cc_link_if (
	input wire logic plug_flip_in // 0: partner on pin a, 1: on pin b
);
	logic pin_a_drv;
	logic pin_a_oe;
	logic pin_b_drv;
	logic pin_b_oe;
	logic partner_drv;
	logic partner_oe;
	logic pin_a_lvl;
	logic pin_b_lvl;
	logic partner_lvl;

	// wired-and of active drivers over a high dc bias
	assign pin_a_lvl = (~pin_a_oe | pin_a_drv) & (plug_flip_in | ~partner_oe | partner_drv);
	assign pin_b_lvl = (~pin_b_oe | pin_b_drv) & (~plug_flip_in | ~partner_oe | partner_drv);
	assign partner_lvl = plug_flip_in ? pin_b_lvl : pin_a_lvl;

	modport device_mp (
		output pin_a_drv, pin_a_oe, pin_b_drv, pin_b_oe,
		input pin_a_lvl, pin_b_lvl
	);
	modport partner_mp (
		output partner_drv, partner_oe,
		input partner_lvl
	);
endinterface

// ===== core/bmc_tx_buf.sv
`timescale 1ns/1ns
module bmc_tx_buf #(
	parameter int WIDTH = bmc_pkg::TX_BUF_WIDTH,
	parameter int DEPTH = bmc_pkg::TX_BUF_DEPTH
) (
	input wire logic clk_in, // system clock
	input wire logic rst_b_in, // sync reset, active low
	input wire logic in_valid_in, // writer has a word
	input wire logic [WIDTH-1:0] in_data_in, // word written
	output logic in_ready_out, // room for a word
	output logic out_valid_out, // word available
	output logic [WIDTH-1:0] out_data_out, // oldest word
	input wire logic out_ready_in // reader takes the word
);
	import bmc_pkg::*;
	localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : bad_shape
		$error("buffer depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic next_in_ready, next_out_valid, push, pop;

	// pointer and flag update; flags registered from next count
	always_comb begin
		push = in_valid_in & in_ready_out;
		pop = out_valid_out & out_ready_in;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_in_ready = next_count != FULL_CNT;
		next_out_valid = next_count != '0;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_out <= next_in_ready;
			out_valid_out <= next_out_valid;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	assign out_data_out = mem[rd_ptr];
endmodule // bmc_tx_buf

// ===== core/bmc_device_end.sv
`timescale 1ns/1ns
// Behaviour
// [R1] transition at every bit start
// [R2] extra mid-bit transition for a one
// [R3] disparity stays within half a bit
// [R4] preamble starts by driving low
// [R5] lost first edge is tolerated
// [R6] closing edge after the last bit
// [R7] drive only while sending, else release
// [R8] only one driver; others stay released
// [R9] one pin chosen by orientation
// [R10] mid-bit edge decodes one, else zero
module bmc_codec #(
	parameter int HALF_CYC = bmc_pkg::HALF_BIT_CYC
) (
	input wire logic clk_in, // system clock
	input wire logic rst_b_in, // sync reset, active low
	input wire logic tx_valid_in, // next bit offered
	input wire logic tx_bit_in, // bit value
	output logic tx_ready_out, // bit taken when valid
	output logic line_drv_out, // coded level
	output logic line_oe_out, // driving the wire
	input wire logic line_lvl_in, // synchronised wire level
	output logic rx_bit_out, // decoded bit
	output logic rx_valid_out, // one-cycle bit strobe
	output logic rx_end_out, // one-cycle end of frame
	output logic rx_busy_out // frame being received
);
	import bmc_pkg::*;
	localparam int CW = $clog2(4 * HALF_CYC + 2);
	typedef logic [CW-1:0] cnt_t;
	localparam cnt_t HALF_M1 = cnt_t'(HALF_CYC - 1);
	localparam cnt_t UI_NOM = cnt_t'(2 * HALF_CYC);
	localparam cnt_t UI_MAX = cnt_t'(2 * HALF_CYC + HALF_CYC / 2);
	localparam cnt_t CNT_ONE = cnt_t'(1);
	localparam logic [3:0] GUARD = 4'(RX_GUARD_CYC);

	if (HALF_CYC < 4 || RX_GUARD_CYC > 15) begin : bad_timing
		$error("half bit must be at least 4 cycles");
	end

	tx_state_t tx_state, next_tx_state;
	cnt_t cnt, next_cnt;
	logic phase, next_phase, lvl, next_lvl, oe, next_oe;
	logic cur_bit, next_cur_bit, nbit, next_nbit, have, next_have;
	logic next_tx_ready, take;
	logic [3:0] guard, next_guard;

	// encoder sequencing
	always_comb begin
		next_tx_state = tx_state;
		next_cnt = cnt;
		next_phase = phase;
		next_lvl = lvl;
		next_oe = oe;
		next_cur_bit = cur_bit;
		next_nbit = nbit;
		next_have = have;
		next_guard = (guard != 4'h0) ? guard - 4'h1 : guard;
		take = tx_ready_out & tx_valid_in;
		if (take) begin
			next_nbit = tx_bit_in;
			next_have = 1'b1;
		end
		case (tx_state)
			TX_IDLE: begin
				if (take) begin
					next_tx_state = TX_LEAD;
					next_oe = 1'b1; // [R7]
					next_lvl = 1'b0; // [R4]
					next_cnt = HALF_M1;
				end
			end
			TX_LEAD: begin
				if (cnt == '0) begin
					next_tx_state = TX_BITS;
					next_lvl = ~lvl; // [R1]
					next_phase = 1'b0;
					next_cnt = HALF_M1;
					next_cur_bit = nbit;
					next_have = 1'b0;
				end else begin
					next_cnt = cnt - CNT_ONE;
				end
			end
			TX_BITS: begin
				if (cnt != '0) begin
					next_cnt = cnt - CNT_ONE;
				end else if (!phase) begin
					next_phase = 1'b1;
					next_cnt = HALF_M1;
					if (cur_bit) begin
						next_lvl = ~lvl; // [R2] [R3]
					end
				end else begin
					next_lvl = ~lvl; // [R1] [R6]
					next_cnt = HALF_M1;
					if (have) begin
						next_phase = 1'b0;
						next_cur_bit = nbit;
						next_have = 1'b0;
					end else begin
						next_tx_state = TX_TAIL;
					end
				end
			end
			TX_TAIL: begin
				if (cnt == '0) begin
					next_tx_state = TX_IDLE;
					next_oe = 1'b0; // [R7] [R8]
					next_lvl = LINE_IDLE_LVL;
					next_guard = GUARD;
				end else begin
					next_cnt = cnt - CNT_ONE;
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
				next_oe = 1'b0;
				next_lvl = LINE_IDLE_LVL;
			end
		endcase
		// idle start refused while someone else is talking
		next_tx_ready = (next_tx_state == TX_IDLE && next_guard == 4'h0 && !rx_busy_out) // [R8]
			|| (next_tx_state == TX_BITS && next_phase && next_cnt == CNT_ONE);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tx_state <= TX_IDLE;
			cnt <= '0;
			phase <= 1'b0;
			lvl <= LINE_IDLE_LVL;
			oe <= 1'b0;
			cur_bit <= 1'b0;
			nbit <= 1'b0;
			have <= 1'b0;
			guard <= 4'h0;
			tx_ready_out <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			cnt <= next_cnt;
			phase <= next_phase;
			lvl <= next_lvl;
			oe <= next_oe;
			cur_bit <= next_cur_bit;
			nbit <= next_nbit;
			have <= next_have;
			guard <= next_guard;
			tx_ready_out <= next_tx_ready;
		end
	end

	assign line_drv_out = lvl;
	assign line_oe_out = oe;

	cnt_t icnt, next_icnt, ui_est, next_ui_est, thr;
	logic [CW:0] ui_sum;
	logic prev, next_prev, act, next_act, pend, next_pend;
	logic next_rx_bit, next_rx_valid, next_rx_end, rx_en, edge_seen;

	// decoder: edge spacing against the recovered bit period
	always_comb begin
		next_prev = line_lvl_in;
		next_icnt = icnt;
		next_ui_est = ui_est;
		next_act = act;
		next_pend = pend;
		next_rx_bit = rx_bit_out;
		next_rx_valid = 1'b0;
		next_rx_end = 1'b0;
		rx_en = (tx_state == TX_IDLE) && (guard == 4'h0) && !oe;
		edge_seen = line_lvl_in ^ prev;
		thr = ui_est - (ui_est >> 2);
		ui_sum = {1'b0, ui_est} + {1'b0, icnt};
		if (!rx_en) begin
			next_act = 1'b0;
			next_pend = 1'b0;
		end else if (!act) begin
			if (edge_seen) begin
				next_act = 1'b1; // [R5]
				next_icnt = '0;
				next_pend = 1'b0;
			end
		end else begin
			next_icnt = icnt + CNT_ONE;
			if (edge_seen) begin
				next_icnt = '0;
				if (icnt < thr) begin
					if (pend) begin
						next_rx_bit = 1'b1; // [R10]
						next_rx_valid = 1'b1;
					end
					next_pend = ~pend;
				end else begin
					next_rx_bit = 1'b0; // [R10]
					next_rx_valid = 1'b1;
					next_pend = 1'b0;
					if (icnt <= UI_MAX) begin
						next_ui_est = ui_sum[CW:1];
					end
				end
			end else if (icnt > ui_est + (ui_est >> 1)) begin
				next_act = 1'b0;
				next_rx_end = 1'b1;
				next_ui_est = UI_NOM;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			prev <= LINE_IDLE_LVL;
			icnt <= '0;
			ui_est <= UI_NOM;
			act <= 1'b0;
			pend <= 1'b0;
			rx_bit_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_end_out <= 1'b0;
		end else begin
			prev <= next_prev;
			icnt <= next_icnt;
			ui_est <= next_ui_est;
			act <= next_act;
			pend <= next_pend;
			rx_bit_out <= next_rx_bit;
			rx_valid_out <= next_rx_valid;
			rx_end_out <= next_rx_end;
		end
	end

	assign rx_busy_out = act;
endmodule // bmc_codec

module bmc_device_end (
	input wire logic clk_in, // system clock
	input wire logic rst_b_in, // sync reset, active low
	cc_link_if.device_mp link, // both wire pins
	input wire logic config_channel_pin_sel_in, // orientation: 0 pin a, 1 pin b
	input wire logic tx_valid_in, // bit offered to send
	input wire logic tx_bit_in, // bit value
	output logic tx_ready_out, // buffer has room
	output logic rx_bit_out, // decoded bit
	output logic rx_valid_out, // bit strobe
	output logic rx_end_out, // frame ended
	output logic tx_busy_out, // wire driven by us
	output logic orient_out // pin in use
);
	import bmc_pkg::*;

	logic a_s1, a_s2, b_s1, b_s2, sel_s1, sel_s2;
	logic sel, next_sel, lvl_sel;
	logic a_drv, a_oe, b_drv, b_oe, next_a_oe, next_b_oe;
	logic buf_valid, buf_bit, codec_ready, codec_drv, codec_oe, codec_rx_busy;

	// two-stage synchronisers for pins and strap
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			a_s1 <= LINE_IDLE_LVL;
			a_s2 <= LINE_IDLE_LVL;
			b_s1 <= LINE_IDLE_LVL;
			b_s2 <= LINE_IDLE_LVL;
			sel_s1 <= PIN_SEL_A;
			sel_s2 <= PIN_SEL_A;
		end else begin
			a_s1 <= link.pin_a_lvl;
			a_s2 <= a_s1;
			b_s1 <= link.pin_b_lvl;
			b_s2 <= b_s1;
			sel_s1 <= config_channel_pin_sel_in;
			sel_s2 <= sel_s1;
		end
	end

	// orientation only changes between frames; one pin drives, other stays off
	always_comb begin
		next_sel = (codec_oe || codec_rx_busy) ? sel : sel_s2; // [R9]
		lvl_sel = (sel == PIN_SEL_B) ? b_s2 : a_s2; // [R9]
		next_a_oe = codec_oe && (sel == PIN_SEL_A); // [R7] [R9]
		next_b_oe = codec_oe && (sel == PIN_SEL_B); // [R7] [R9]
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sel <= PIN_SEL_A;
			a_drv <= LINE_IDLE_LVL;
			b_drv <= LINE_IDLE_LVL;
			a_oe <= 1'b0;
			b_oe <= 1'b0;
			tx_busy_out <= 1'b0;
		end else begin
			sel <= next_sel;
			a_drv <= codec_drv;
			b_drv <= codec_drv;
			a_oe <= next_a_oe;
			b_oe <= next_b_oe;
			tx_busy_out <= codec_oe;
		end
	end

	assign link.pin_a_drv = a_drv;
	assign link.pin_a_oe = a_oe;
	assign link.pin_b_drv = b_drv;
	assign link.pin_b_oe = b_oe;
	assign orient_out = sel;

	bmc_tx_buf #(
		.WIDTH(TX_BUF_WIDTH),
		.DEPTH(TX_BUF_DEPTH)
	) u_buf (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(tx_valid_in),
		.in_data_in(tx_bit_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(buf_valid),
		.out_data_out(buf_bit),
		.out_ready_in(codec_ready)
	);

	bmc_codec #(
		.HALF_CYC(HALF_BIT_CYC)
	) u_codec (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.tx_valid_in(buf_valid),
		.tx_bit_in(buf_bit),
		.tx_ready_out(codec_ready),
		.line_drv_out(codec_drv),
		.line_oe_out(codec_oe),
		.line_lvl_in(lvl_sel),
		.rx_bit_out(rx_bit_out),
		.rx_valid_out(rx_valid_out),
		.rx_end_out(rx_end_out),
		.rx_busy_out(codec_rx_busy)
	);
endmodule // bmc_device_end

// ===== core/bmc_partner_end.sv
`timescale 1ns/1ns
module bmc_partner_end (
	input wire logic clk_in, // system clock
	input wire logic rst_b_in, // sync reset, active low
	cc_link_if.partner_mp link, // the partner's wire
	input wire logic tx_valid_in, // bit offered to send
	input wire logic tx_bit_in, // bit value
	output logic tx_ready_out, // bit taken when valid
	output logic rx_bit_out, // decoded bit
	output logic rx_valid_out, // bit strobe
	output logic rx_end_out, // frame ended
	output logic tx_busy_out // wire driven by us
);
	import bmc_pkg::*;

	logic l_s1, l_s2, drv, oe, codec_drv, codec_oe;

	// synchroniser on the wire, registered driver
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			l_s1 <= LINE_IDLE_LVL;
			l_s2 <= LINE_IDLE_LVL;
			drv <= LINE_IDLE_LVL;
			oe <= 1'b0;
			tx_busy_out <= 1'b0;
		end else begin
			l_s1 <= link.partner_lvl;
			l_s2 <= l_s1;
			drv <= codec_drv;
			oe <= codec_oe; // [R8]
			tx_busy_out <= codec_oe;
		end
	end

	assign link.partner_drv = drv;
	assign link.partner_oe = oe;

	bmc_codec #(
		.HALF_CYC(HALF_BIT_CYC)
	) u_codec (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.tx_valid_in(tx_valid_in),
		.tx_bit_in(tx_bit_in),
		.tx_ready_out(tx_ready_out),
		.line_drv_out(codec_drv),
		.line_oe_out(codec_oe),
		.line_lvl_in(l_s2),
		.rx_bit_out(rx_bit_out),
		.rx_valid_out(rx_valid_out),
		.rx_end_out(rx_end_out),
		.rx_busy_out()
	);
endmodule // bmc_partner_end

// ===== bench/pd_bmc_link_checker.sv
`timescale 1ns/1ns
module pd_bmc_link_checker #(
	parameter int HALF = bmc_pkg::HALF_BIT_CYC
) (
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // reset
	input wire logic plug_flip_in, // partner on pin b
	input wire logic pin_a_drv_in, // pin a level
	input wire logic pin_a_oe_in, // pin a enable
	input wire logic pin_b_drv_in, // pin b level
	input wire logic pin_b_oe_in, // pin b enable
	input wire logic partner_drv_in, // partner level
	input wire logic partner_oe_in // partner enable
);
	import bmc_pkg::*;
	logic dev_oe;
	logic dev_drv;
	logic prev_dev_oe;
	logic prev_dev_drv;
	logic prev_par_oe;
	logic prev_par_drv;
	int run_dev;
	int run_par;
	int next_run_dev;
	int next_run_par;
	// pin the device drives
	assign dev_oe = pin_a_oe_in | pin_b_oe_in;
	assign dev_drv = pin_a_oe_in ? pin_a_drv_in : pin_b_drv_in;
	// length of the current driven level
	always_comb begin
		next_run_dev = (dev_oe && prev_dev_oe && dev_drv == prev_dev_drv) ? run_dev + 1 : 1;
		next_run_par = (partner_oe_in && prev_par_oe && partner_drv_in == prev_par_drv) ? run_par + 1 : 1;
	end
	always_ff @(posedge clk_in) begin
		prev_dev_oe <= rst_b_in & dev_oe;
		prev_dev_drv <= dev_drv;
		prev_par_oe <= rst_b_in & partner_oe_in;
		prev_par_drv <= partner_drv_in;
		run_dev <= rst_b_in ? next_run_dev : 1;
		run_par <= rst_b_in ? next_run_par : 1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	a_one_pin_only: assert property (!(pin_a_oe_in && pin_b_oe_in))
		else $error("device drives both pins");
	a_single_driver: assert property (!(partner_oe_in && (plug_flip_in ? pin_b_oe_in : pin_a_oe_in)))
		else $error("two drivers on the wire");
	a_lead_low_dev: assert property ($rose(dev_oe) |-> !dev_drv [*8])
		else $error("device lead not low");
	a_lead_low_par: assert property ($rose(partner_oe_in) |-> (!partner_drv_in && partner_oe_in) [*4])
		else $error("partner lead not low");
	a_edge_space_dev: assert property ((dev_oe && prev_dev_oe && dev_drv != prev_dev_drv)
		|-> (run_dev == HALF || run_dev == 2 * HALF)) else $error("device edge spacing wrong");
	a_edge_space_par: assert property ((partner_oe_in && prev_par_oe && partner_drv_in != prev_par_drv)
		|-> (run_par == HALF || run_par == 2 * HALF)) else $error("partner edge spacing wrong");
	a_close_hold_dev: assert property ($fell(dev_oe) |-> run_dev == HALF)
		else $error("device closing level wrong");
	a_close_hold_par: assert property ($fell(partner_oe_in) |-> run_par == HALF)
		else $error("partner closing level wrong");
	c_dev_frame: cover property ($fell(dev_oe));
	c_par_frame: cover property ($fell(partner_oe_in));
	c_pin_b_used: cover property (pin_b_oe_in);
endmodule // pd_bmc_link_checker

// ===== bench/pd_biphase_mark_phy_tb.sv
`timescale 1ns/1ns
module pd_biphase_mark_phy_tb;
	import bmc_pkg::*;
	typedef struct packed {logic flip; logic dir; logic [3:0] n; logic [7:0] bits;} row_t;
	row_t rows [0:5] = '{'{1'b0, 1'b0, 4'h8, 8'hA5}, '{1'b1, 1'b0, 4'h8, 8'h3C}, '{1'b0, 1'b1, 4'h8, 8'hF0},
		'{1'b1, 1'b1, 4'h8, 8'h96}, '{1'b0, 1'b1, 4'h1, 8'h01}, '{1'b1, 1'b0, 4'h1, 8'h00}};
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic flip = 1'b0;
	logic sel = 1'b0;
	logic dv = 1'b0;
	logic db = 1'b0;
	logic pv = 1'b0;
	logic pb = 1'b0;
	logic d_rdy, d_bit, d_val, d_end, d_busy, orient;
	logic p_rdy, p_bit, p_val, p_end, p_busy;
	logic dq[$];
	logic pq[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int k;
	always #5 clk_in = ~clk_in;
	cc_link_if u_cc_link_if (.plug_flip_in(flip));
	bmc_device_end u_bmc_device_end (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(u_cc_link_if),
		.config_channel_pin_sel_in(sel), .tx_valid_in(dv), .tx_bit_in(db), .tx_ready_out(d_rdy),
		.rx_bit_out(d_bit), .rx_valid_out(d_val), .rx_end_out(d_end), .tx_busy_out(d_busy), .orient_out(orient));
	bmc_partner_end u_bmc_partner_end (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(u_cc_link_if),
		.tx_valid_in(pv), .tx_bit_in(pb), .tx_ready_out(p_rdy), .rx_bit_out(p_bit), .rx_valid_out(p_val),
		.rx_end_out(p_end), .tx_busy_out(p_busy));
	pd_bmc_link_checker u_pd_bmc_link_checker (.clk_in(clk_in), .rst_b_in(rst_b_in), .plug_flip_in(flip),
		.pin_a_drv_in(u_cc_link_if.pin_a_drv), .pin_a_oe_in(u_cc_link_if.pin_a_oe),
		.pin_b_drv_in(u_cc_link_if.pin_b_drv), .pin_b_oe_in(u_cc_link_if.pin_b_oe),
		.partner_drv_in(u_cc_link_if.partner_drv), .partner_oe_in(u_cc_link_if.partner_oe));
	// collect decoded bits mid-cycle
	always @(negedge clk_in) begin
		if (d_val === 1'b1) dq.push_back(d_bit);
		if (p_val === 1'b1) pq.push_back(p_bit);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// offer bits one by one, held until taken
	task automatic send(input logic dir, input logic [7:0] b, input int n);
		int w;
		for (int i = 0; i < n; i++) begin
			if (dir) begin
				dv = 1'b1;
				db = b[i];
			end else begin
				pv = 1'b1;
				pb = b[i];
			end
			w = 0;
			while ((dir ? d_rdy : p_rdy) !== 1'b1 && w < 2000) begin
				@(posedge clk_in);
				#1;
				w++;
			end
			if (w >= 2000) error_cnt++;
			@(posedge clk_in);
			#1;
		end
		dv = 1'b0;
		pv = 1'b0;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// wires released by every party
	task automatic check_released();
		check({u_cc_link_if.pin_a_oe, u_cc_link_if.pin_b_oe, u_cc_link_if.partner_oe}, 3'h0);
	endtask
	// hang guard
	initial begin
		#500000;
		error_cnt++;
		close_out();
	end
	initial begin
		wait_clk(19);
		check_released();
		check({d_busy, p_busy, orient}, 3'h0);
		wait_clk(1);
		rst_b_in = 1'b1;
		foreach (rows[r]) begin
			flip = rows[r].flip;
			sel = rows[r].flip;
			wait_clk(8);
			check(orient, rows[r].flip);
			fork
				send(rows[r].dir, rows[r].bits, rows[r].n);
			join_none
			if (rows[r].dir && rows[r].n > 3) begin
				wait_clk(20);
				check(d_rdy, 1'b0);
			end
			wait fork;
			k = 0;
			while ((rows[r].dir ? p_end : d_end) !== 1'b1 && k < 4000) begin
				wait_clk(1);
				k++;
			end
			check(k < 4000, 1'b1);
			wait_clk(10);
			check_released();
			if (rows[r].dir) begin
				check(pq.size(), rows[r].n);
				for (int i = 0; i < rows[r].n; i++) check(pq[i], rows[r].bits[i]);
				check(dq.size(), 0);
			end else begin
				check(dq.size(), rows[r].n);
				for (int i = 0; i < rows[r].n; i++) check(dq[i], rows[r].bits[i]);
				check(pq.size(), 0);
			end
			dq.delete();
			pq.delete();
		end
		// device on pin a while partner sits on pin b
		flip = 1'b1;
		sel = 1'b0;
		wait_clk(8);
		send(1'b1, 8'h55, 4);
		k = 0;
		while (d_busy !== 1'b0 && k < 4000) begin
			wait_clk(1);
			k++;
		end
		check(k < 4000, 1'b1);
		wait_clk(700);
		check(pq.size(), 0);
		check_released();
		// reset in mid-frame, then a clean frame on pin a
		flip = 1'b0;
		sel = 1'b0;
		wait_clk(8);
		pv = 1'b1;
		pb = 1'b1;
		wait_clk(400);
		check(p_busy, 1'b1);
		rst_b_in = 1'b0;
		pv = 1'b0;
		wait_clk(3);
		check_released();
		check({d_busy, p_busy, d_rdy, p_rdy, d_val, p_val}, 6'h00);
		rst_b_in = 1'b1;
		wait_clk(2);
		check({d_rdy, p_rdy}, 2'h3);
		dq.delete();
		pq.delete();
		send(1'b0, 8'hC3, 8);
		k = 0;
		while (d_end !== 1'b1 && k < 4000) begin
			wait_clk(1);
			k++;
		end
		check(k < 4000, 1'b1);
		check(dq.size(), 8);
		for (int i = 0; i < 8; i++) check(dq[i], (8'hC3 >> i) & 8'h01);
		wait_clk(10);
		check_released();
		close_out();
	end
endmodule // pd_biphase_mark_phy_tb
